// File: hdl/mpc_pkg.sv
package mpc_pkg;
    localparam int CLK_HZ = 25_000_000;
    // hold time on a request input, in milliseconds (more than half a second)
    localparam int HOLD_MS = 500;
    localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    // a level must have been low this long before a rise counts as an edge
    localparam int LOW_MS = 10;
    localparam int LOW_CYC = (CLK_HZ / 1000) * LOW_MS;
    // startup interval until commands are accepted, seconds
    localparam int BOOT_MIN_S = 2;
    localparam int BOOT_MAX_S = 20;
    localparam int BOOT_CYC = CLK_HZ * BOOT_MIN_S;
    // network detach allowance before power is cut, milliseconds
    localparam int DETACH_MS = 1000;
    localparam int DETACH_CYC = (CLK_HZ / 1000) * DETACH_MS;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [2:0] SYNC_ZERO = 3'h0;
    localparam int SYNC_MID = 1;
    localparam int SYNC_LAST = 2;

    typedef enum logic [4:0] {
        MPC_OFF = 5'h01,
        MPC_BOOT = 5'h02,
        MPC_READY = 5'h04,
        MPC_DETACH = 5'h08,
        MPC_HALT = 5'h10
    } mpc_state_e;
endpackage

// File: hdl/mpc_edge_hold.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_edge_hold
    import mpc_pkg::*;
#(
    parameter int HOLD = HOLD_CYC,
    parameter int LOWQ = LOW_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // raw pin
    input wire logic i_pin,
    // filtered level and qualified request
    output logic o_level,
    output logic o_req
);
    typedef struct packed {
        logic [2:0] sync;
        logic armed;
        logic held;
        logic fired;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] hi_cnt;
        logic level;
        logic req;
    } mpc_eh_s;

    mpc_eh_s st;
    mpc_eh_s next_st;
    logic agree_hi;
    logic agree_lo;

    // only the second and third stages are compared
    assign agree_hi = st.sync[SYNC_MID] & st.sync[SYNC_LAST];
    assign agree_lo = ~st.sync[SYNC_MID] & ~st.sync[SYNC_LAST];

    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[SYNC_MID:0], i_pin};
        next_st.req = 1'b0;
        if (agree_lo) begin
            next_st.level = 1'b0;
            next_st.held = 1'b0;
            next_st.fired = 1'b0;
            next_st.hi_cnt = CNT_ZERO;
            // a rise counts only after a settled low: slow creep is ignored
            if (st.low_cnt >= CNT_W'(LOWQ)) begin
                next_st.armed = 1'b1;
            end else begin
                next_st.low_cnt = st.low_cnt + CNT_ONE;
            end
        end else if (agree_hi) begin
            next_st.level = 1'b1;
            next_st.low_cnt = CNT_ZERO;
            if (!st.level) begin
                next_st.held = st.armed;
                next_st.armed = 1'b0;
            end
            if (st.held && !st.fired) begin
                if (st.hi_cnt >= CNT_W'(HOLD)) begin
                    next_st.req = 1'b1;
                    next_st.fired = 1'b1;
                end else begin
                    next_st.hi_cnt = st.hi_cnt + CNT_ONE;
                end
            end
        end else begin
            // disagreement mid-transition restarts the low qualification
            next_st.low_cnt = CNT_ZERO;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
    assign o_req = st.req;

    req_after_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_req |-> $past(st.level) && $past(st.hi_cnt) >= CNT_W'(HOLD))
        else $error("request fired without full hold");
    req_needs_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_req |-> $past(st.held))
        else $error("request fired without qualified edge");
endmodule
`default_nettype wire

// File: hdl/mpc_power_ctrl.sv
// Function
// - by default the controller powers the modem on its own when supply appears and then supervises it.
// - after supply is first applied the initial power state is on.
// - the modem powers up when the power-on request is held high for more than half a second.
// - the modem powers down when the power-off request is held high for more than half a second.
// - requests are only honoured after a clean rise from a settled low level.
// - slow or tiny transitions are not treated as valid edges.
// - the shutdown command first detaches from the network and then removes module power.
// - after power-on the modem becomes ready for commands within a two to twenty second startup.
// - once startup completes network registration starts by itself.
// - there is no special reset or forced power-down beyond the request inputs and command.
`timescale 1ns/1ps
`default_nettype none
module mpc_power_ctrl
    import mpc_pkg::*;
#(
    parameter int HOLD = HOLD_CYC,
    parameter int LOWQ = LOW_CYC,
    parameter int BOOT = BOOT_CYC,
    parameter int DETACH = DETACH_CYC
) (
    // clock and reset (reset stands for supply application)
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // request pins from the host
    input wire logic i_power_on_request_input,
    input wire logic i_power_off_request_input,
    // software shutdown command strobe
    input wire logic i_software_shutdown_command,
    // network side
    input wire logic i_detach_done,
    // power and status
    output logic o_module_power_en,
    output logic o_ready,
    output logic o_net_register_start,
    output logic o_net_detach_req,
    output logic o_cmd_busy
);
    typedef struct packed {
        mpc_state_e state;
        logic [CNT_W-1:0] cnt;
        logic pwr;
        logic ready;
        logic reg_start;
        logic detach;
        logic busy;
    } mpc_pc_s;

    mpc_pc_s st;
    mpc_pc_s next_st;
    logic on_lvl;
    logic off_lvl;
    logic on_req;
    logic off_req;
    logic both;

    mpc_edge_hold #(.HOLD(HOLD), .LOWQ(LOWQ)) u_on (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin(i_power_on_request_input),
        .o_level(on_lvl),
        .o_req(on_req)
    );

    mpc_edge_hold #(.HOLD(HOLD), .LOWQ(LOWQ)) u_off (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pin(i_power_off_request_input),
        .o_level(off_lvl),
        .o_req(off_req)
    );

    // both levels active blocks the request-driven state changes
    assign both = on_lvl & off_lvl;

    always_comb begin
        next_st = st;
        next_st.reg_start = 1'b0;
        unique case (st.state)
            MPC_OFF: begin
                if (on_req && !both) begin
                    next_st.state = MPC_BOOT;
                    next_st.cnt = CNT_ZERO;
                end
            end
            MPC_BOOT: begin
                if (off_req && !both) begin
                    next_st.state = MPC_OFF;
                end else if (st.cnt >= CNT_W'(BOOT)) begin
                    next_st.state = MPC_READY;
                    next_st.reg_start = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + CNT_ONE;
                end
            end
            MPC_READY: begin
                if (off_req && !both) begin
                    next_st.state = MPC_OFF;
                end else if (i_software_shutdown_command) begin
                    next_st.state = MPC_DETACH;
                    next_st.cnt = CNT_ZERO;
                end
            end
            MPC_DETACH: begin
                // detach finishes or its allowance expires before power goes
                if (i_detach_done || st.cnt >= CNT_W'(DETACH)) begin
                    next_st.state = MPC_HALT;
                end else begin
                    next_st.cnt = st.cnt + CNT_ONE;
                end
            end
            MPC_HALT: begin
                next_st.state = MPC_OFF;
            end
            default: begin
                next_st.state = MPC_OFF;
            end
        endcase
        next_st.pwr = (next_st.state != MPC_OFF) && (next_st.state != MPC_HALT);
        next_st.ready = (next_st.state == MPC_READY);
        next_st.detach = (next_st.state == MPC_DETACH);
        next_st.busy = (next_st.state == MPC_BOOT) || (next_st.state == MPC_DETACH);
    end

    // supply-on acts as reset: come up powered and booting, no other recovery path
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st.state <= MPC_BOOT;
            st.cnt <= CNT_ZERO;
            st.pwr <= 1'b1;
            st.ready <= 1'b0;
            st.reg_start <= 1'b0;
            st.detach <= 1'b0;
            st.busy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_module_power_en = st.pwr;
    assign o_ready = st.ready;
    assign o_net_register_start = st.reg_start;
    assign o_net_detach_req = st.detach;
    assign o_cmd_busy = st.busy;

    off_cuts_power_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        off_req && !both && (st.state == MPC_READY) |=> !o_module_power_en)
        else $error("power-off request did not cut power");
    on_powers_up_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        on_req && !both && (st.state == MPC_OFF) |=> o_module_power_en && o_cmd_busy)
        else $error("power-on request did not power up");
    both_holds_state_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        both && !i_software_shutdown_command && (st.state inside {MPC_OFF, MPC_READY})
        |=> $stable(o_module_power_en))
        else $error("state changed with both requests active");
    detach_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $fell(o_module_power_en) && st.state == MPC_HALT |-> $past(o_net_detach_req))
        else $error("shutdown cut power without detach");
    ready_starts_reg_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(o_ready) |-> o_net_register_start)
        else $error("registration not started at ready");
    boot_then_ready_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(o_ready) |-> $past(st.state) == MPC_BOOT && $past(st.cnt) >= CNT_W'(BOOT))
        else $error("ready before startup interval");
    cmd_detaches_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_software_shutdown_command && st.state == MPC_READY && !(off_req && !both)
        |=> o_net_detach_req && o_module_power_en)
        else $error("shutdown command did not start detach");
    power_on_default_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(i_resetn) |-> o_module_power_en)
        else $error("not powered after supply applied");
endmodule
`default_nettype wire

// File: testbench/mpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_host_model (
    // clock
    input wire logic i_clk_sys,
    // network side
    input wire logic i_net_detach_req,
    output logic o_detach_done,
    // request pins
    output logic o_power_on_request_input,
    output logic o_power_off_request_input
);
    int delay = 1;
    int cnt = 0;
    initial begin
        o_detach_done = 1'b0;
        o_power_on_request_input = 1'b0;
        o_power_off_request_input = 1'b0;
    end
    // delays past the allowance check that power is cut anyway
    always @(posedge i_clk_sys) begin
        o_detach_done <= i_net_detach_req && cnt == delay;
        cnt <= i_net_detach_req ? cnt + 1 : 0;
    end
    // clean rise from ground, held, then settled low
    task automatic press(input logic on, input logic off, input int hi, input int lo);
        @(posedge i_clk_sys);
        o_power_on_request_input <= on;
        o_power_off_request_input <= off;
        repeat (hi) @(posedge i_clk_sys);
        o_power_on_request_input <= 1'b0;
        o_power_off_request_input <= 1'b0;
        repeat (lo) @(posedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// File: testbench/modem_power_onoff_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module modem_power_onoff_control_tb_top;
    localparam int HOLD = 20;
    localparam int LOWQ = 8;
    localparam int BOOT = 30;
    localparam int DETACH = 15;
    // supply kept off, a scaled stand-in for the ten second minimum
    localparam int OFF_CYC = 20;
    logic i_clk_sys = 1'b0;
    logic i_resetn;
    logic i_software_shutdown_command;
    logic pin_on, pin_off, done, busy;
    logic o_module_power_en, o_ready, o_net_register_start, o_net_detach_req;
    logic [2:0] exp_q[$];
    logic prev_pwr;
    bit run = 1'b0;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 i_clk_sys = ~i_clk_sys;

    mpc_power_ctrl #(.HOLD(HOLD), .LOWQ(LOWQ), .BOOT(BOOT), .DETACH(DETACH)) dut_u (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_power_on_request_input(pin_on), .i_power_off_request_input(pin_off),
        .i_software_shutdown_command(i_software_shutdown_command),
        .i_detach_done(done), .o_module_power_en(o_module_power_en),
        .o_ready(o_ready), .o_net_register_start(o_net_register_start),
        .o_net_detach_req(o_net_detach_req), .o_cmd_busy(busy)
    );
    mpc_host_model host_u (
        .i_clk_sys(i_clk_sys), .i_net_detach_req(o_net_detach_req),
        .o_detach_done(done), .o_power_on_request_input(pin_on),
        .o_power_off_request_input(pin_off)
    );

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_q(input string name);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 400) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk("pending results", 3'h0, 3'(exp_q.size()));
        $display("test %s done", name);
    endtask

    // ceiling well above the roughly 450 cycles the tests need
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            close_out();
        end
    end
    // outputs settle after the rising edge, so results are watched on the falling one
    always @(negedge i_clk_sys) begin
        if (run && (o_module_power_en !== prev_pwr || o_net_register_start === 1'b1)) begin
            if (exp_q.size() == 0) begin
                chk("result count", 3'h0, 3'h1);
            end else begin
                chk("power ready detach", exp_q.pop_front(),
                    {o_module_power_en, o_ready, o_net_detach_req});
            end
        end
        prev_pwr = o_module_power_en;
    end

    initial begin
        i_resetn = 1'b0;
        i_software_shutdown_command = 1'b0;
        void'($urandom(32'h2EBE));
        repeat (10) @(posedge i_clk_sys);
        chk("reset outputs", 3'h4, {o_module_power_en, o_ready, o_net_register_start});
        chk("busy in reset", 3'h1, {2'h0, busy});
        run = 1'b1;
        repeat (10) @(posedge i_clk_sys);
        exp_q.push_back(3'h6);
        i_resetn <= 1'b1;
        wait_q("boot");
        host_u.press(1'b1, 1'b1, HOLD + 10, LOWQ + 4);
        repeat (3) host_u.press(1'b0, 1'b1, 3, 3);
        host_u.press(1'b0, 1'b1, HOLD + 10, LOWQ + 4);
        wait_q("ignored edges");
        exp_q.push_back(3'h0);
        host_u.press(1'b0, 1'b1, HOLD + $urandom_range(4, 12), LOWQ + 4);
        host_u.press(1'b1, 1'b1, HOLD + 10, LOWQ + 4);
        wait_q("off request");
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back(3'h4);
            exp_q.push_back(3'h6);
            host_u.press(1'b1, 1'b0, HOLD + $urandom_range(4, 12), LOWQ + 4);
            wait_q("on request");
            chk("busy when ready", 3'h0, {2'h0, busy});
            host_u.delay = i ? 40 : $urandom_range(1, 8);
            exp_q.push_back(3'h0);
            @(posedge i_clk_sys);
            i_software_shutdown_command <= 1'b1;
            @(posedge i_clk_sys);
            i_software_shutdown_command <= 1'b0;
            @(posedge i_clk_sys);
            chk("detach phase", 3'h6, {o_module_power_en, o_net_detach_req, o_ready});
            chk("busy in detach", 3'h1, {2'h0, busy});
            wait_q("shutdown");
        end
        // supply removed only after a clean shutdown, kept off, then restored
        exp_q.push_back(3'h4);
        exp_q.push_back(3'h6);
        i_resetn <= 1'b0;
        repeat (OFF_CYC) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        wait_q("supply cycle");
        close_out();
    end
endmodule
`default_nettype wire
